// [hw/ccd_pkg.sv]
// Package: register map, field layout, reset values and carrier types of the chop/current-detect block
package ccd_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]  CCD_IDX_CONFIG     = 8'h06;
   localparam logic [7:0]  CCD_IDX_THR_HIGH   = 8'h07;
   localparam logic [7:0]  CCD_IDX_THR_LOW    = 8'h08;
   localparam logic [7:0]  CCD_IDX_CH_CFG     = 8'h09;
   localparam logic [7:0]  CCD_IDX_IRQ_STAT   = 8'h20;
   localparam logic [7:0]  CCD_IDX_IRQ_MASK   = 8'h21;
   localparam logic [11:0] CCD_ADDR_CONFIG    = {2'h0, CCD_IDX_CONFIG, 2'h0};
   localparam logic [11:0] CCD_ADDR_THR_HIGH  = {2'h0, CCD_IDX_THR_HIGH, 2'h0};
   localparam logic [11:0] CCD_ADDR_THR_LOW   = {2'h0, CCD_IDX_THR_LOW, 2'h0};
   localparam logic [11:0] CCD_ADDR_CH_CFG    = {2'h0, CCD_IDX_CH_CFG, 2'h0};
   localparam logic [11:0] CCD_ADDR_IRQ_STAT  = {2'h0, CCD_IDX_IRQ_STAT, 2'h0};
   localparam logic [11:0] CCD_ADDR_IRQ_MASK  = {2'h0, CCD_IDX_IRQ_MASK, 2'h0};
   // Field positions
   localparam int CCD_CFG_DELAY_LSB   = 9;
   localparam int CCD_CFG_CHOP_BIT    = 8;
   localparam int CCD_CFG_ALL_BIT     = 7;
   localparam int CCD_CFG_COUNT_LSB   = 4;
   localparam int CCD_CFG_LEN_LSB     = 1;
   localparam int CCD_CFG_DETECT_BIT  = 0;
   localparam int CCD_THL_UPPER_LSB   = 8;
   localparam int CCD_THL_DC_LSB      = 0;
   localparam int CCD_IRQ_DETECT_BIT  = 0;
   localparam int CCD_IRQ_WINDOW_BIT  = 1;
   localparam int CCD_IRQ_SETTLE_BIT  = 2;
   // Reset values and write masks
   localparam logic [15:0] CCD_RST_CONFIG     = 16'h0600;
   localparam logic [15:0] CCD_RST_THR_HIGH   = 16'h0000;
   localparam logic [15:0] CCD_RST_THR_LOW    = 16'h0000;
   localparam logic [3:0]  CCD_RST_DELAY      = 4'h3;
   localparam logic [15:0] CCD_THL_WMASK      = 16'hFF0F;
   localparam logic [15:0] CCD_CFG_WMASK      = 16'h1FFF;
   // Window lengths in conversion periods, per code
   localparam logic [11:0] CCD_LEN_TABLE [8] = '{12'd128, 12'd256, 12'd512, 12'd768,
                                                  12'd1280, 12'd1792, 12'd2560, 12'd3584};

   typedef struct packed {
      logic [3:0] settle_delay;
      logic       chop_on;
      logic       all_channels;
      logic [2:0] exceed_count;
      logic [2:0] window_length;
      logic       detect_mode_on;
      logic [23:0] threshold;
   } ccd_cfg_t;

   typedef struct packed {
      logic       detect;
      logic       window_done;
      logic       settle_done;
   } ccd_evt_t;
endpackage

// [hw/ccd_settle.sv]
// Global-chop settling delay timer
`timescale 1ns/1ps
`default_nettype none
module ccd_settle
   import ccd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Control
   input  wire logic       chop_on,
   input  wire logic [3:0] delay_code,
   input  wire logic       meas_req,
   // Status
   output logic            meas_go,
   output logic            busy
);
   typedef struct packed {
      logic [16:0] cnt;
      logic        busy;
      logic        go;
   } ccd_settle_t;

   ccd_settle_t s_r;
   ccd_settle_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.go = 1'b0;
      if (s_r.busy) begin
         if (s_r.cnt == 17'h00001) begin
            s_nxt.busy = 1'b0;
            s_nxt.go   = 1'b1;
         end
         s_nxt.cnt = s_r.cnt - 17'h00001;
      end else if (meas_req) begin
         if (chop_on) begin
            // Wait 2^(n+1) modulator periods before the measurement
            s_nxt.busy = 1'b1;
            s_nxt.cnt  = 17'h00001 << ({1'b0, delay_code} + 5'h01);
         end else begin
            s_nxt.go = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign meas_go = s_r.go;
   assign busy    = s_r.busy;
endmodule
`default_nettype wire

// [hw/ccd_detect.sv]
// Current-detect engine: per-channel threshold compare, exceedance count, window
`timescale 1ns/1ps
`default_nettype none
module ccd_detect
   import ccd_pkg::*;
#(
   parameter int NCH = 6
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Configuration
   input  wire ccd_cfg_t          cfg,
   input  wire logic              start,
   // Conversion results
   input  wire logic              sample_valid,
   input  wire logic [NCH*24-1:0] sample_data,
   // Results
   output logic                   detect,
   output logic                   window_done,
   output logic                   active
);
   typedef struct packed {
      logic              active;
      logic [11:0]       periods;
      logic [NCH-1:0][7:0] count;
      logic              detect;
      logic              done;
   } ccd_det_t;

   ccd_det_t d_r;
   ccd_det_t d_nxt;
   logic [NCH-1:0] exceed;
   logic [7:0]     target;

   assign target = 8'h01 << cfg.exceed_count;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // Signed sample value strictly above the signed threshold counts as an exceedance
         assign exceed[g]  = $signed(sample_data[g*24 +: 24]) > $signed(cfg.threshold);
      end
   endgenerate

   function automatic logic [NCH-1:0] reached_n(input logic [NCH-1:0][7:0] c, input logic [7:0] t);
      logic [NCH-1:0] r;
      r = '0;
      for (int i = 0; i < NCH; i++) begin
         r[i] = (c[i] >= t);
      end
      return r;
   endfunction

   always_comb begin
      d_nxt = d_r;
      d_nxt.detect = 1'b0;
      d_nxt.done   = 1'b0;
      if (!cfg.detect_mode_on) begin
         d_nxt.active = 1'b0;
      end else if (start && !d_r.active) begin
         d_nxt.active  = 1'b1;
         d_nxt.periods = '0;
         d_nxt.count   = '0;
      end else if (d_r.active && sample_valid) begin
         for (int i = 0; i < NCH; i++) begin
            if (exceed[i] && d_r.count[i] != 8'hFF) begin
               d_nxt.count[i] = d_r.count[i] + 8'h01;
            end
         end
         d_nxt.periods = d_r.periods + 12'h001;
         // Window length from the length code
         if (d_nxt.periods == CCD_LEN_TABLE[cfg.window_length]) begin
            d_nxt.active = 1'b0;
            d_nxt.done   = 1'b1;
            // Any channel or all channels qualify
            d_nxt.detect = cfg.all_channels ? (&reached_n(d_nxt.count, target))
                                            : (|reached_n(d_nxt.count, target));
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         d_r <= '0;
      end else begin
         d_r <= d_nxt;
      end
   end

   assign detect      = d_r.detect;
   assign window_done = d_r.done;
   assign active      = d_r.active;
endmodule
`default_nettype wire

// [hw/ccd_top.sv]
// Chop and current-detect configuration block with APB register access
//
// Function
// - With chop on (bit 8), each measurement waits 2^(n+1) modulator periods, code n reset 0011b.
// - Bit 7 at 0 triggers detection on any channel, at 1 only when all channels qualify.
// - Bits 6:4 code k needs 2^k exceedances to trigger, 1 to 128, reset 000b.
// - Bits 3:1 select a window of 128/256/512/768/1280/1792/2560/3584 conversion periods.
// - Bit 0 enables detection; the 24-bit threshold splits over high register and low bits 15:8.
// - Bits 7:4 of the threshold-low register read zero and ignore writes.
// - Bits 3:0 of the threshold-low register hold the read-write dc-removal setting, reset 0000b.
// - A channel's dc-removal filter follows the shared setting unless its disable bit is 1.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccd_top
   import ccd_pkg::*;
#(
   parameter int NCH = 6
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Conversion results and measurement request
   input  wire logic              meas_req,
   input  wire logic              sample_valid,
   input  wire logic [NCH*24-1:0] sample_data,
   // Controls to the conversion path
   output logic                   meas_go,
   output logic                   chop_on,
   output logic [NCH-1:0][3:0]    dc_removal_setting,
   output logic                   detect_flag,
   // Interrupt
   output logic                   irq
);
   typedef struct packed {
      logic [15:0]     config_reg;
      logic [15:0]     thr_high;
      logic [7:0]      thr_lower;
      logic [3:0]      dc_set;
      logic [NCH-1:0]  dc_off;
      logic [2:0]      stat;
      logic [2:0]      mask;
      logic [31:0]     rdata;
      logic            ready;
      logic            slverr;
      logic            irq;
      logic            chop;
      logic [NCH-1:0][3:0] dc_out;
      logic            det_flag;
   } ccd_top_t;

   ccd_top_t t_r;
   ccd_top_t t_nxt;
   ccd_cfg_t cfg;
   logic     settle_go;
   logic     det_pulse;
   logic     win_pulse;
   logic     access;
   logic     hit;
   logic [15:0] wd;
   ccd_evt_t evt;

   // Decoded configuration to the engines
   always_comb begin
      cfg.settle_delay   = t_r.config_reg[CCD_CFG_DELAY_LSB +: 4];
      cfg.chop_on        = t_r.config_reg[CCD_CFG_CHOP_BIT];
      cfg.all_channels   = t_r.config_reg[CCD_CFG_ALL_BIT];
      cfg.exceed_count   = t_r.config_reg[CCD_CFG_COUNT_LSB +: 3];
      cfg.window_length  = t_r.config_reg[CCD_CFG_LEN_LSB +: 3];
      cfg.detect_mode_on = t_r.config_reg[CCD_CFG_DETECT_BIT];
      // Threshold assembled from both registers
      cfg.threshold      = {t_r.thr_high, t_r.thr_lower};
   end

   ccd_settle u_settle (
      .clk        (clk),
      .resetn     (resetn),
      .chop_on    (cfg.chop_on),
      .delay_code (cfg.settle_delay),
      .meas_req   (meas_req),
      .meas_go    (settle_go),
      .busy       ()
   );

   ccd_detect #(.NCH(NCH)) u_detect (
      .clk          (clk),
      .resetn       (resetn),
      .cfg          (cfg),
      .start        (settle_go),
      .sample_valid (sample_valid),
      .sample_data  (sample_data),
      .detect       (det_pulse),
      .window_done  (win_pulse),
      .active       ()
   );

   assign evt.detect      = det_pulse;
   assign evt.window_done = win_pulse;
   assign evt.settle_done = settle_go & cfg.chop_on;
   assign access          = psel & penable & ~t_r.ready;
   assign wd              = pwdata[15:0];

   always_comb begin
      t_nxt = t_r;
      t_nxt.ready  = 1'b0;
      t_nxt.slverr = 1'b0;
      hit = 1'b1;
      if (access) begin
         t_nxt.ready = 1'b1;
         t_nxt.rdata = '0;
         case (paddr)
            CCD_ADDR_CONFIG: begin
               // Reserved bits 15:13 are masked to zero on write by CCD_CFG_WMASK
               if (pwrite) t_nxt.config_reg = wd & CCD_CFG_WMASK;
               t_nxt.rdata = {16'h0000, t_r.config_reg};
            end
            CCD_ADDR_THR_HIGH: begin
               if (pwrite) t_nxt.thr_high = wd;
               t_nxt.rdata = {16'h0000, t_r.thr_high};
            end
            CCD_ADDR_THR_LOW: begin
               if (pwrite) begin
                  t_nxt.thr_lower = wd[CCD_THL_UPPER_LSB +: 8];
                  t_nxt.dc_set    = wd[CCD_THL_DC_LSB +: 4];
               end
               // Bits 7:4 always read zero, writes dropped
               t_nxt.rdata = {16'h0000, t_r.thr_lower, 4'h0, t_r.dc_set};
            end
            CCD_ADDR_CH_CFG: begin
               if (pwrite) t_nxt.dc_off = wd[NCH-1:0];
               t_nxt.rdata = {{(32-NCH){1'b0}}, t_r.dc_off};
            end
            CCD_ADDR_IRQ_STAT: begin
               t_nxt.rdata = {29'h0, t_r.stat};
            end
            CCD_ADDR_IRQ_MASK: begin
               if (pwrite) t_nxt.mask = wd[2:0];
               t_nxt.rdata = {29'h0, t_r.mask};
            end
            default: begin
               hit = 1'b0;
               t_nxt.slverr = 1'b1;
            end
         endcase
      end
      // Status: write one to clear, a new event wins over the clear
      if (access && pwrite && hit && paddr == CCD_ADDR_IRQ_STAT) begin
         t_nxt.stat = t_r.stat & ~wd[2:0];
      end
      t_nxt.stat = t_nxt.stat | {evt.settle_done, evt.window_done, evt.detect};
      t_nxt.irq  = |(t_nxt.stat & t_nxt.mask);
      t_nxt.chop = t_nxt.config_reg[CCD_CFG_CHOP_BIT];
      if (det_pulse) begin
         t_nxt.det_flag = 1'b1;
      end else if (settle_go) begin
         t_nxt.det_flag = 1'b0;
      end
      for (int i = 0; i < NCH; i++) begin
         // Per-channel disable overrides shared setting
         t_nxt.dc_out[i] = t_nxt.dc_off[i] ? 4'h0 : t_nxt.dc_set;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         t_r            <= '0;
         t_r.config_reg <= CCD_RST_CONFIG;
         t_r.thr_high   <= CCD_RST_THR_HIGH;
      end else begin
         t_r <= t_nxt;
      end
   end

   assign prdata             = t_r.rdata;
   assign pready             = t_r.ready;
   assign pslverr            = t_r.slverr;
   assign irq                = t_r.irq;
   assign chop_on            = t_r.chop;
   assign dc_removal_setting = t_r.dc_out;
   assign detect_flag        = t_r.det_flag;
   assign meas_go            = settle_go;
endmodule
`default_nettype wire

// [dv/ccd_properties.sv]
// Checker: port-level properties of the chop and current-detect block
`timescale 1ns/1ps
`default_nettype none
module ccd_properties
   import ccd_pkg::*;
#(
   parameter int NCH = 6
)
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              resetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Measurement path
   input wire logic              meas_req,
   input wire logic              sample_valid,
   input wire logic [NCH*24-1:0] sample_data,
   input wire logic              meas_go,
   input wire logic              chop_on,
   input wire logic [NCH-1:0][3:0] dc_removal_setting,
   input wire logic              detect_flag,
   input wire logic              irq
);
   logic        wcfg;
   logic [3:0]  code_r;
   logic [16:0] wait_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   assign wcfg = psel && penable && pready && pwrite && paddr == CCD_ADDR_CONFIG;
   // Shadow of the delay code and edges since the last request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         code_r <= CCD_RST_DELAY;
         wait_r <= 17'h0;
      end else begin
         if (wcfg) begin
            code_r <= pwdata[12:9];
         end
         wait_r <= meas_req ? 17'h1 : wait_r + 17'h1;
      end
   end
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_cfg_wr; wcfg; endsequence
   property p_answer; s_wait |=> pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_ready_access; pready |-> psel && penable; endproperty
   property p_refused; pslverr |-> pready && prdata == 32'h0; endproperty
   property p_chop_follow; $changed(chop_on) |-> s_cfg_wr; endproperty
   property p_go_direct; meas_req && !chop_on |=> meas_go; endproperty
   property p_go_delay; meas_go |-> wait_r == (chop_on ? (17'h1 << (code_r + 1)) + 17'h1 : 17'h1); endproperty
   property p_go_pulse; meas_go |=> !meas_go; endproperty
   property p_flag_clear; meas_go |=> !detect_flag; endproperty
   property p_flag_cause; $rose(detect_flag) |-> $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3);
   endproperty
   a_answer: assert property (p_answer) else $error("No ready one cycle after access");
   a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held over two cycles");
   a_ready_access: assert property (p_ready_access) else $error("Ready outside access phase");
   a_refused: assert property (p_refused) else $error("Error response with data");
   a_chop_follow: assert property (p_chop_follow) else $error("Chop output moved without write");
   a_go_direct: assert property (p_go_direct) else $error("Start late with chop off");
   a_go_delay: assert property (p_go_delay) else $error("Wrong settle delay");
   a_go_pulse: assert property (p_go_pulse) else $error("Start held over two cycles");
   a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared by start");
   a_flag_cause: assert property (p_flag_cause) else $error("Flag rose without samples");
endmodule
bind ccd_top ccd_properties #(.NCH(NCH)) i_props (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .meas_req(meas_req), .sample_valid(sample_valid), .sample_data(sample_data), .meas_go(meas_go),
   .chop_on(chop_on), .dc_removal_setting(dc_removal_setting), .detect_flag(detect_flag), .irq(irq));
`default_nettype wire

// [dv/tb_top.sv]
// Testbench: registers, settle delay, detection and interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ccd_pkg::*;
;
   logic           clk = 1'b0;
   logic           resetn = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [11:0]    paddr = 12'h0;
   logic [31:0]    pwdata = 32'h0;
   logic           meas_req = 1'b0;
   logic           sample_valid = 1'b0;
   logic [143:0]   sample_data = '0;
   logic [31:0]    prdata, rd;
   logic           pready, pslverr, er, meas_go, chop_on, detect_flag, irq;
   logic [5:0][3:0] dc;
   int             error_cnt = 0;
   int             n_tests = 0;
   int             c;
   int             dl[3] = '{0, 1, 15};
   logic [11:0]    ra[6] = '{CCD_ADDR_CONFIG, CCD_ADDR_THR_HIGH, CCD_ADDR_THR_LOW, CCD_ADDR_THR_LOW,
                             CCD_ADDR_IRQ_MASK, CCD_ADDR_CH_CFG};
   logic [31:0]    rw[6] = '{32'h0000FFFF, 32'hFFFFA5C3, 32'h0000FFFF, 32'h000000F5, 32'h7, 32'h3F};
   logic [31:0]    rx[6] = '{32'h00001FFF, 32'h0000A5C3, 32'h0000FF0F, 32'h00000005, 32'h7, 32'h3F};
   // Detection rows: config, exceeding samples, channels, samples, flag, window done
   int             dr[8][6] = '{'{'h11, 2, 'h04, 128, 1, 1}, '{'h11, 1, 'h04, 128, 0, 1},
                                '{'h91, 2, 'h04, 128, 0, 1}, '{'h10, 2, 'h04, 128, 0, 0},
                                '{'h71, 127, 'h01, 128, 0, 1}, '{'h71, 128, 'h01, 128, 1, 1},
                                '{'h13, 2, 'h01, 256, 1, 1}, '{'h91, 2, 'h3F, 128, 1, 1}};
   always #5 clk = ~clk;
   ccd_top #(.NCH(6)) i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas_req(meas_req), .sample_valid(sample_valid), .sample_data(sample_data), .meas_go(meas_go),
      .chop_on(chop_on), .dc_removal_setting(dc), .detect_flag(detect_flag), .irq(irq));
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         error_cnt++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic go(output int n);
      @(posedge clk);
      meas_req <= 1'b1;
      @(posedge clk);
      meas_req <= 1'b0;
      for (n = 1; n < 70000; n++) begin
         @(negedge clk);
         if (meas_go === 1'b1) break;
         @(posedge clk);
      end
      if (n == 70000) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task automatic run_win(input int r[6]);
      int i, k, n;
      apb(1'b1, CCD_ADDR_CONFIG, r[0]);
      apb(1'b1, CCD_ADDR_IRQ_STAT, 32'h7);
      go(n);
      for (i = 0; i < r[3]; i++) begin
         @(posedge clk);
         sample_valid <= 1'b1;
         for (k = 0; k < 6; k++) sample_data[24*k +: 24] <= (r[2][k] && i < r[1]) ? 24'h11 : 24'h10;
      end
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (4) @(posedge clk);
      chk(detect_flag, r[4]);
      chk(irq, r[4]);
      apb(1'b0, CCD_ADDR_IRQ_STAT, 32'h0);
      chk(rd, 2 * r[5] + r[4]);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, CCD_ADDR_CONFIG, 32'h0);
      chk(rd, 32'h0600);
      apb(1'b0, CCD_ADDR_THR_HIGH, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, CCD_ADDR_THR_LOW, 32'h0);
      chk(rd, 32'h0);
      for (int j = 0; j < 6; j++) begin
         apb(1'b1, ra[j], rw[j]);
         apb(1'b0, ra[j], 32'h0);
         chk(rd, rx[j]);
      end
      apb(1'b0, 12'hFFC, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, CCD_ADDR_THR_HIGH, 32'h0);
      apb(1'b1, CCD_ADDR_THR_LOW, 32'h100A);
      apb(1'b1, CCD_ADDR_CH_CFG, 32'h2);
      repeat (2) @(posedge clk);
      chk({dc[2], dc[1], dc[0]}, 12'hA0A);
      for (int j = 0; j < 3; j++) begin
         apb(1'b1, CCD_ADDR_CONFIG, (dl[j] << 9) | 'h100);
         go(c);
         chk(c, (1 << (dl[j] + 1)) + 1);
         chk(chop_on, 32'h1);
      end
      apb(1'b0, CCD_ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h4);
      apb(1'b1, CCD_ADDR_CONFIG, 32'h0);
      go(c);
      chk(c, 1);
      chk(chop_on, 32'h0);
      apb(1'b1, CCD_ADDR_IRQ_MASK, 32'h1);
      for (int j = 0; j < 8; j++) run_win(dr[j]);
      apb(1'b1, CCD_ADDR_IRQ_MASK, 32'h0);
      chk(irq, 0);
      apb(1'b1, CCD_ADDR_IRQ_MASK, 32'h1);
      chk(irq, 1);
      apb(1'b1, CCD_ADDR_IRQ_STAT, 32'h1);
      chk(irq, 0);
      run_win('{'h13, 2, 'h01, 255, 0, 0});
      finish_test();
   end
endmodule
`default_nettype wire
